// File: inc/ict_consts.vh
// Purpose: shared constants of the instruction cycle timing and alu block
// Assumes: the decoder upstream maps opcodes to the operation classes below
// Notes:   operation class codes are internal to this block
`ifndef ICT_CONSTS_VH
`define ICT_CONSTS_VH

// timing: system clock period and clocks per instruction cycle
`define ICT_CLK_NS 40
`define ICT_CLK_PER_ICYC 4
`define ICT_ICYC_NS (`ICT_CLK_NS * `ICT_CLK_PER_ICYC)
`define ICT_PH_LAST 2'h3
`define ICT_PH_FIRST 2'h0

// operation classes presented on op_code
`define ICT_OP_NOP 5'h00
`define ICT_OP_XFER_A_M 5'h01
`define ICT_OP_XFER_M_A 5'h02
`define ICT_OP_XFER_A_I 5'h03
`define ICT_OP_ADD 5'h04
`define ICT_OP_ADC 5'h05
`define ICT_OP_SUB 5'h06
`define ICT_OP_SBC 5'h07
`define ICT_OP_AND 5'h08
`define ICT_OP_OR 5'h09
`define ICT_OP_XOR 5'h0a
`define ICT_OP_COMPL 5'h0b
`define ICT_OP_INC 5'h0c
`define ICT_OP_SUB_ONE 5'h0d
`define ICT_OP_ROT_R 5'h0e
`define ICT_OP_ROT_L 5'h0f
`define ICT_OP_ROT_RC 5'h10
`define ICT_OP_ROT_LC 5'h11
`define ICT_OP_JUMP 5'h12
`define ICT_OP_CALL 5'h13
`define ICT_OP_SUB_EXIT 5'h14
`define ICT_OP_ISR_EXIT 5'h15
`define ICT_OP_TABRD 5'h16
`define ICT_OP_SKBS 5'h17
`define ICT_OP_SKBC 5'h18
`define ICT_OP_CLEAR 5'h19

// reset values and sequencer state codes
`define ICT_ACC_RST 8'h00
`define ICT_PC_RST 12'h000
`define ICT_ST_EXEC 2'h1
`define ICT_ST_FLUSH 2'h2

`endif

// File: logic/ict_phase.v
// Purpose: divides the system clock into instruction cycles of four clocks
// Assumes: single clock domain, asynchronous active low reset
// Notes:   start and end pulses are one clock wide, both from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "ict_consts.vh"

module ict_phase (
    input wire core_clk,
    input wire nrst,
    output reg [1:0] phase_r,
    output reg start_r,
    output reg end_r
);

    wire [1:0] phase_nxt;

    // wrap after the last phase so every cycle is exactly four clocks
    assign phase_nxt = (phase_r == `ICT_PH_LAST) ? `ICT_PH_FIRST : phase_r + 2'h1;

    // pulses are precomputed so they line up with the phase they mark
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= `ICT_PH_FIRST;
            start_r <= 1'b1;
            end_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            start_r <= (phase_nxt == `ICT_PH_FIRST);
            end_r <= (phase_nxt == `ICT_PH_LAST);
        end
    end

endmodule
`default_nettype wire

// File: logic/ict_alu.v
// Purpose: combinational data path for moves, arithmetic, logic and rotates
// Assumes: operand b is the data memory value or the immediate
// Notes:   upd_* say which flags the operation is allowed to change
`timescale 1ns/1ps
`default_nettype none
`include "ict_consts.vh"

module ict_alu (
    input wire [4:0] op,
    input wire [7:0] a,
    input wire [7:0] b,
    input wire cin,
    input wire [2:0] bsel,
    output reg [7:0] res,
    output reg z,
    output reg c,
    output reg ac,
    output reg ov,
    output reg upd_z,
    output reg upd_c,
    output reg upd_aov,
    output reg skip
);

    wire use_c;
    wire [8:0] add9;
    wire [4:0] addn;
    wire [8:0] sub9;
    wire [4:0] subn;

    // with-carry forms fold the carry or borrow into the low bit
    assign use_c = (op == `ICT_OP_ADC) || (op == `ICT_OP_SBC);
    assign add9 = {1'b0, a} + {1'b0, b} + {8'h00, use_c & cin};
    assign addn = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, use_c & cin};
    assign sub9 = {1'b0, a} - {1'b0, b} - {8'h00, use_c & cin};
    assign subn = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, use_c & cin};

    // one case per class; flags default to unchanged
    always @* begin
        res = b;
        c = cin;
        ac = 1'b0;
        ov = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_aov = 1'b0;
        skip = 1'b0;
        case (op)
            `ICT_OP_ADD, `ICT_OP_ADC: begin
                res = add9[7:0];
                c = add9[8];
                ac = addn[4];
                ov = (a[7] == b[7]) && (add9[7] != a[7]);
                upd_z = 1'b1;
                upd_c = 1'b1;
                upd_aov = 1'b1;
            end
            `ICT_OP_SUB, `ICT_OP_SBC: begin
                res = sub9[7:0];
                c = sub9[8];
                ac = subn[4];
                ov = (a[7] != b[7]) && (sub9[7] != a[7]);
                upd_z = 1'b1;
                upd_c = 1'b1;
                upd_aov = 1'b1;
            end
            `ICT_OP_AND: begin
                res = a & b;
                upd_z = 1'b1;
            end
            `ICT_OP_OR: begin
                res = a | b;
                upd_z = 1'b1;
            end
            `ICT_OP_XOR: begin
                res = a ^ b;
                upd_z = 1'b1;
            end
            `ICT_OP_COMPL: begin
                res = ~b;
                upd_z = 1'b1;
            end
            `ICT_OP_INC: begin
                res = b + 8'h01;
                upd_z = 1'b1;
            end
            `ICT_OP_SUB_ONE: begin
                res = b - 8'h01;
                upd_z = 1'b1;
            end
            `ICT_OP_ROT_R: res = {b[0], b[7:1]};
            `ICT_OP_ROT_L: res = {b[6:0], b[7]};
            `ICT_OP_ROT_RC: begin
                res = {cin, b[7:1]};
                c = b[0];
                upd_c = 1'b1;
            end
            `ICT_OP_ROT_LC: begin
                res = {b[6:0], cin};
                c = b[7];
                upd_c = 1'b1;
            end
            `ICT_OP_SKBS: skip = b[bsel];
            `ICT_OP_SKBC: skip = ~b[bsel];
            default: res = b;
        endcase
        z = (res == 8'h00);
    end

endmodule
`default_nettype wire

// File: logic/ict_core.v
// Purpose: instruction cycle sequencer with accumulator, flags and pc
// Assumes: op_* inputs hold the instruction at pc_r for the whole cycle
// Notes:   execution happens on the last clock of each instruction cycle
//
// What this block does
// - one instruction cycle is exactly four system clocks.
// - most instructions take one cycle; branch, call, table read take two.
// - jump, call, return and interrupt return get one extra cycle.
// - writing the pc low byte acts as a jump and costs a cycle.
// - skip takes one cycle, plus one more when the skip is taken.
// - carry on addition above 255, borrow on subtraction below zero.
// - increment and decrement by one, into memory or accumulator.
// - logical results set zero flag when zero, clear it otherwise.
// - rotate one bit, plain wraps, through-carry swaps end bit with carry.
// - moves: memory to acc, acc to memory, immediate to acc.
// - logical operations take one operand from the accumulator, result to acc or memory.
// - add and subtract update zero, carry, aux carry and overflow.
// - logical and complement change only the zero flag.
`timescale 1ns/1ps
`default_nettype none
`include "ict_consts.vh"

module ict_core #(
    parameter PC_W = 12,
    parameter STK_D = 8,
    parameter STK_AW = 3
) (
    input wire core_clk,
    input wire nrst,
    input wire [4:0] op_code,
    input wire [7:0] op_operand,
    input wire [2:0] op_bit,
    input wire op_to_mem,
    input wire op_dest_pc_low,
    input wire [PC_W-1:0] op_addr,
    input wire [7:0] tbl_data,
    output wire [1:0] icyc_phase,
    output wire icyc_start,
    output reg [PC_W-1:0] pc_r,
    output reg [7:0] acc_r,
    output reg z_r,
    output reg c_r,
    output reg ac_r,
    output reg ov_r,
    output reg mem_we_r,
    output reg [7:0] mem_wd_r,
    output reg flush_r,
    output reg tbl_rd_r,
    output reg isr_exit_r
);

    wire ph_end;
    wire [7:0] alu_res;
    wire alu_z;
    wire alu_c;
    wire alu_ac;
    wire alu_ov;
    wire upd_z;
    wire upd_c;
    wire upd_aov;
    wire skip_hit;
    wire [PC_W-1:0] pc_inc;

    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg adv_r;
    reg adv_nxt;
    reg tbl_r;
    reg tbl_nxt;
    reg [PC_W-1:0] pc_nxt;
    reg [7:0] acc_nxt;
    reg z_nxt;
    reg c_nxt;
    reg ac_nxt;
    reg ov_nxt;
    reg mem_we_nxt;
    reg [7:0] mem_wd_nxt;
    reg isr_exit_nxt;
    reg [STK_AW-1:0] sp_r;
    reg [STK_AW-1:0] sp_nxt;
    reg push;
    reg [PC_W-1:0] stk [0:STK_D-1];

    // four clock phase generator; ph_end marks the execute clock
    ict_phase u_phase (
        .core_clk(core_clk),
        .nrst(nrst),
        .phase_r(icyc_phase),
        .start_r(icyc_start),
        .end_r(ph_end)
    );

    // data path shared by all data manipulating classes
    ict_alu u_alu (
        .op(op_code),
        .a(acc_r),
        .b(op_operand),
        .cin(c_r),
        .bsel(op_bit),
        .res(alu_res),
        .z(alu_z),
        .c(alu_c),
        .ac(alu_ac),
        .ov(alu_ov),
        .upd_z(upd_z),
        .upd_c(upd_c),
        .upd_aov(upd_aov),
        .skip(skip_hit)
    );

    assign pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};

    // decode and sequence; all but the write and isr exit pulses hold except on the execute clock
    always @* begin
        st_nxt = st_r;
        adv_nxt = adv_r;
        tbl_nxt = tbl_r;
        pc_nxt = pc_r;
        acc_nxt = acc_r;
        z_nxt = z_r;
        c_nxt = c_r;
        ac_nxt = ac_r;
        ov_nxt = ov_r;
        mem_we_nxt = 1'b0;
        mem_wd_nxt = mem_wd_r;
        isr_exit_nxt = 1'b0;
        sp_nxt = sp_r;
        push = 1'b0;
        if (ph_end) begin
            case (st_r)
                `ICT_ST_EXEC: begin
                    pc_nxt = pc_inc;
                    adv_nxt = 1'b0;
                    tbl_nxt = 1'b0;
                    // flag updates are gated per class by the alu masks
                    if (upd_z) begin
                        z_nxt = alu_z;
                    end
                    if (upd_c) begin
                        c_nxt = alu_c;
                    end
                    if (upd_aov) begin
                        ac_nxt = alu_ac;
                        ov_nxt = alu_ov;
                    end
                    case (op_code)
                        `ICT_OP_XFER_A_M, `ICT_OP_XFER_A_I: begin
                            acc_nxt = op_operand;
                        end
                        `ICT_OP_XFER_M_A, `ICT_OP_CLEAR: begin
                            mem_wd_nxt = (op_code == `ICT_OP_CLEAR) ? 8'h00 : acc_r;
                            if (op_dest_pc_low) begin
                                pc_nxt = {pc_r[PC_W-1:8], mem_wd_nxt};
                                st_nxt = `ICT_ST_FLUSH;
                            end else begin
                                mem_we_nxt = 1'b1;
                            end
                        end
                        `ICT_OP_ADD, `ICT_OP_ADC, `ICT_OP_SUB, `ICT_OP_SBC,
                        `ICT_OP_AND, `ICT_OP_OR, `ICT_OP_XOR, `ICT_OP_COMPL,
                        `ICT_OP_INC, `ICT_OP_SUB_ONE, `ICT_OP_ROT_R, `ICT_OP_ROT_L,
                        `ICT_OP_ROT_RC, `ICT_OP_ROT_LC: begin
                            // memory forms write back, the others load acc
                            if (!op_to_mem) begin
                                acc_nxt = alu_res;
                            end else if (op_dest_pc_low) begin
                                pc_nxt = {pc_r[PC_W-1:8], alu_res};
                                st_nxt = `ICT_ST_FLUSH;
                            end else begin
                                mem_wd_nxt = alu_res;
                                mem_we_nxt = 1'b1;
                            end
                        end
                        `ICT_OP_JUMP: begin
                            pc_nxt = op_addr;
                            st_nxt = `ICT_ST_FLUSH;
                        end
                        `ICT_OP_CALL: begin
                            push = 1'b1;
                            sp_nxt = sp_r + {{(STK_AW-1){1'b0}}, 1'b1};
                            pc_nxt = op_addr;
                            st_nxt = `ICT_ST_FLUSH;
                        end
                        `ICT_OP_SUB_EXIT, `ICT_OP_ISR_EXIT: begin
                            sp_nxt = sp_r - {{(STK_AW-1){1'b0}}, 1'b1};
                            pc_nxt = stk[sp_nxt];
                            isr_exit_nxt = (op_code == `ICT_OP_ISR_EXIT);
                            st_nxt = `ICT_ST_FLUSH;
                        end
                        `ICT_OP_TABRD: begin
                            tbl_nxt = 1'b1;
                            st_nxt = `ICT_ST_FLUSH;
                        end
                        `ICT_OP_SKBS, `ICT_OP_SKBC: begin
                            // a taken skip fetches pc+1 only to throw it away
                            if (skip_hit) begin
                                adv_nxt = 1'b1;
                                st_nxt = `ICT_ST_FLUSH;
                            end
                        end
                        default: begin
                            pc_nxt = pc_inc;
                        end
                    endcase
                end
                `ICT_ST_FLUSH: begin
                    // op_* inputs are ignored here: they belong to the old path
                    st_nxt = `ICT_ST_EXEC;
                    adv_nxt = 1'b0;
                    tbl_nxt = 1'b0;
                    if (adv_r) begin
                        pc_nxt = pc_inc;
                    end
                    if (tbl_r) begin
                        acc_nxt = tbl_data;
                    end
                end
                default: begin
                    st_nxt = `ICT_ST_EXEC;
                end
            endcase
        end
    end

    // sequencer and architectural state
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= `ICT_ST_EXEC;
            adv_r <= 1'b0;
            tbl_r <= 1'b0;
            pc_r <= `ICT_PC_RST;
            acc_r <= `ICT_ACC_RST;
            z_r <= 1'b0;
            c_r <= 1'b0;
            ac_r <= 1'b0;
            ov_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_wd_r <= 8'h00;
            flush_r <= 1'b0;
            tbl_rd_r <= 1'b0;
            isr_exit_r <= 1'b0;
            sp_r <= {STK_AW{1'b0}};
        end else begin
            st_r <= st_nxt;
            adv_r <= adv_nxt;
            tbl_r <= tbl_nxt;
            pc_r <= pc_nxt;
            acc_r <= acc_nxt;
            z_r <= z_nxt;
            c_r <= c_nxt;
            ac_r <= ac_nxt;
            ov_r <= ov_nxt;
            mem_we_r <= mem_we_nxt;
            mem_wd_r <= mem_wd_nxt;
            flush_r <= (st_nxt == `ICT_ST_FLUSH);
            tbl_rd_r <= tbl_nxt;
            isr_exit_r <= isr_exit_nxt;
            sp_r <= sp_nxt;
        end
    end

    // return stack; wraps silently on overflow, deeper nesting is lost
    always @(posedge core_clk) begin
        if (push) begin
            stk[sp_r] <= pc_inc;
        end
    end

endmodule
`default_nettype wire

// File: dv/ict_core_sva.sv
// Purpose: assertions on the ports of the instruction cycle core
// Assumes: one clock, asynchronous active low reset
// Notes:   bound into every ict_core instance
`timescale 1ns/1ps
`default_nettype none
module ict_core_sva #(
    parameter PC_W = 12
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [1:0] icyc_phase,
    input wire logic icyc_start,
    input wire logic [PC_W-1:0] pc_r,
    input wire logic [7:0] acc_r,
    input wire logic z_r,
    input wire logic c_r,
    input wire logic ac_r,
    input wire logic ov_r,
    input wire logic mem_we_r,
    input wire logic flush_r,
    input wire logic tbl_rd_r,
    input wire logic isr_exit_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // three quiet clocks, then the next start
    sequence s_gap;
        !icyc_start [*3] ##1 icyc_start;
    endsequence
    // the extra cycle is one whole instruction cycle, never more
    sequence s_flush;
        flush_r [*4] ##1 !flush_r;
    endsequence
    // rose, not level: start sits high through reset
    property p_icyc;
        $rose(icyc_start) |=> s_gap;
    endproperty
    a_icyc: assert property (p_icyc) else $error("cycle not four clocks");
    property p_phase;
        icyc_phase == 2'h3 |=> icyc_start && icyc_phase == 2'h0;
    endproperty
    a_phase: assert property (p_phase) else $error("phase wrap wrong");
    property p_hold;
        !icyc_start |-> $stable(pc_r) && $stable({acc_r, z_r, c_r, ac_r, ov_r});
    endproperty
    a_hold: assert property (p_hold) else $error("state moved mid cycle");
    property p_flush;
        $rose(flush_r) |-> icyc_start ##0 s_flush;
    endproperty
    a_flush: assert property (p_flush) else $error("extra cycle length");
    property p_mem;
        mem_we_r |-> icyc_start && !flush_r ##1 !mem_we_r;
    endproperty
    a_mem: assert property (p_mem) else $error("memory write pulse");
    property p_tbl;
        tbl_rd_r |-> flush_r;
    endproperty
    a_tbl: assert property (p_tbl) else $error("table read outside flush");
    property p_isr;
        isr_exit_r |-> icyc_start && flush_r ##1 !isr_exit_r;
    endproperty
    a_isr: assert property (p_isr) else $error("isr exit pulse");
    property p_disc;
        flush_r && !tbl_rd_r && icyc_phase == 2'h3 |=> $stable({acc_r, z_r, c_r});
    endproperty
    a_disc: assert property (p_disc) else $error("prefetch not discarded");
endmodule
bind ict_core ict_core_sva #(.PC_W(PC_W)) u_sva (
    .core_clk(core_clk), .nrst(nrst), .icyc_phase(icyc_phase),
    .icyc_start(icyc_start), .pc_r(pc_r), .acc_r(acc_r), .z_r(z_r),
    .c_r(c_r), .ac_r(ac_r), .ov_r(ov_r), .mem_we_r(mem_we_r),
    .flush_r(flush_r), .tbl_rd_r(tbl_rd_r), .isr_exit_r(isr_exit_r)
);
`default_nettype wire

// File: dv/ict_core_bench.sv
// Purpose: self-checking bench for the instruction cycle core
// Assumes: results are looked at mid phase 0 after the execute edge
// Notes:   nxt retires the instruction on the inputs and issues the next
`timescale 1ns/1ps
`default_nettype none
`include "ict_consts.vh"
module ict_core_bench;
    logic core_clk, nrst, op_to_mem, op_dest_pc_low, icyc_start;
    logic [4:0] op_code;
    logic [7:0] op_operand, tbl_data, acc_r, mem_wd_r;
    logic [2:0] op_bit;
    logic [11:0] op_addr, pc_r;
    logic [1:0] icyc_phase;
    logic z_r, c_r, ac_r, ov_r, mem_we_r, flush_r, tbl_rd_r, isr_exit_r;
    int err_total, tests_run, cyc;
    ict_core dut (
        .core_clk(core_clk), .nrst(nrst), .op_code(op_code),
        .op_operand(op_operand), .op_bit(op_bit), .op_to_mem(op_to_mem),
        .op_dest_pc_low(op_dest_pc_low), .op_addr(op_addr), .tbl_data(tbl_data),
        .icyc_phase(icyc_phase), .icyc_start(icyc_start), .pc_r(pc_r),
        .acc_r(acc_r), .z_r(z_r), .c_r(c_r), .ac_r(ac_r), .ov_r(ov_r),
        .mem_we_r(mem_we_r), .mem_wd_r(mem_wd_r), .flush_r(flush_r),
        .tbl_rd_r(tbl_rd_r), .isr_exit_r(isr_exit_r)
    );
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a run of about 44 instructions needs some 190 clocks
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            close_out();
        end
    end
    task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task sn(input logic [7:0] a, input logic z, input logic c);
        chk("acc", 12'(acc_r), 12'(a));
        chk("zero", 12'(z_r), 12'(z));
        chk("carry", 12'(c_r), 12'(c));
    endtask
    task av(input logic a, input logic v);
        chk("aux", 12'(ac_r), 12'(a));
        chk("ovf", 12'(ov_r), 12'(v));
    endtask
    task fp(input logic [11:0] pc, input logic f);
        chk("pc", pc_r, pc);
        chk("flush", 12'(flush_r), 12'(f));
        chk("phase", 12'(icyc_phase), 12'h000);
    endtask
    // op_bit and tbl_data ride on the address argument to save ports
    task nxt(input logic [4:0] o, input logic [7:0] d, input logic [1:0] m,
        input logic [11:0] ad);
        repeat (3) @(negedge core_clk);
        @(posedge core_clk);
        op_code <= o;
        op_operand <= d;
        op_to_mem <= m[0];
        op_dest_pc_low <= m[1];
        op_addr <= ad;
        op_bit <= ad[2:0];
        tbl_data <= ad[11:4];
        @(negedge core_clk);
    endtask
    task op(input logic [4:0] o, input logic [7:0] d);
        nxt(o, d, 2'h0, 12'h000);
    endtask
    task t_reset;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        chk("start", 12'(icyc_start), 12'h001);
        fp(12'h000, 1'b0);
        @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        $display("done reset");
    endtask
    task t_alu;
        op(`ICT_OP_XFER_A_I, 8'hf0);
        op(`ICT_OP_ADD, 8'h20);
        sn(8'hf0, 1'b0, 1'b0);
        op(`ICT_OP_SUB, 8'h11);
        sn(8'h10, 1'b0, 1'b1);
        nxt(`ICT_OP_XFER_M_A, 8'h00, 2'h1, 12'h000);
        sn(8'hff, 1'b0, 1'b1);
        op(`ICT_OP_AND, 8'h00);
        chk("we", 12'(mem_we_r), 12'h001);
        chk("wd", 12'(mem_wd_r), 12'h0ff);
        op(`ICT_OP_INC, 8'hff);
        sn(8'h00, 1'b1, 1'b1);
        nxt(`ICT_OP_SUB_ONE, 8'h00, 2'h1, 12'h000);
        sn(8'h00, 1'b1, 1'b1);
        op(`ICT_OP_ROT_RC, 8'h01);
        chk("wd", 12'(mem_wd_r), 12'h0ff);
        sn(8'h00, 1'b0, 1'b1);
        op(`ICT_OP_ROT_LC, 8'h80);
        sn(8'h80, 1'b0, 1'b1);
        op(`ICT_OP_ROT_R, 8'h01);
        sn(8'h01, 1'b0, 1'b1);
        op(`ICT_OP_ROT_L, 8'h81);
        sn(8'h80, 1'b0, 1'b1);
        op(`ICT_OP_XOR, 8'h03);
        sn(8'h03, 1'b0, 1'b1);
        op(`ICT_OP_OR, 8'h50);
        sn(8'h00, 1'b1, 1'b1);
        op(`ICT_OP_COMPL, 8'hff);
        sn(8'h50, 1'b0, 1'b1);
        op(`ICT_OP_ADC, 8'h0f);
        sn(8'h00, 1'b1, 1'b1);
        op(`ICT_OP_SBC, 8'h7f);
        sn(8'h10, 1'b0, 1'b0);
        av(1'b1, 1'b0);
        op(`ICT_OP_ADD, 8'h70);
        sn(8'h91, 1'b0, 1'b1);
        av(1'b1, 1'b0);
        op(`ICT_OP_ADD, 8'h7f);
        sn(8'h01, 1'b0, 1'b1);
        av(1'b0, 1'b0);
        op(`ICT_OP_AND, 8'hff);
        sn(8'h80, 1'b0, 1'b0);
        av(1'b1, 1'b1);
        op(`ICT_OP_NOP, 8'h00);
        sn(8'h80, 1'b0, 1'b0);
        av(1'b1, 1'b1);
        op(`ICT_OP_XFER_A_M, 8'h5a);
        op(`ICT_OP_NOP, 8'h00);
        sn(8'h5a, 1'b0, 1'b0);
        $display("done alu");
    endtask
    task t_flow;
        op(`ICT_OP_XFER_A_I, 8'h3c);
        nxt(`ICT_OP_JUMP, 8'h00, 2'h0, 12'h123);
        op(`ICT_OP_ADD, 8'h55);
        fp(12'h123, 1'b1);
        nxt(`ICT_OP_CALL, 8'h00, 2'h0, 12'h345);
        fp(12'h123, 1'b0);
        chk("acc", 12'(acc_r), 12'h03c);
        op(`ICT_OP_ADD, 8'h55);
        fp(12'h345, 1'b1);
        nxt(`ICT_OP_CALL, 8'h00, 2'h0, 12'h200);
        op(`ICT_OP_NOP, 8'h00);
        fp(12'h200, 1'b1);
        op(`ICT_OP_ISR_EXIT, 8'h00);
        op(`ICT_OP_NOP, 8'h00);
        chk("isr", 12'(isr_exit_r), 12'h001);
        op(`ICT_OP_SUB_EXIT, 8'h00);
        fp(12'h346, 1'b0);
        op(`ICT_OP_NOP, 8'h00);
        op(`ICT_OP_TABRD, 8'h00);
        fp(12'h124, 1'b0);
        nxt(`ICT_OP_NOP, 8'h00, 2'h0, 12'ha50);
        chk("tbl", 12'(tbl_rd_r), 12'h001);
        fp(12'h125, 1'b1);
        nxt(`ICT_OP_SKBS, 8'h08, 2'h0, 12'h003);
        chk("acc", 12'(acc_r), 12'h0a5);
        op(`ICT_OP_ADD, 8'h01);
        fp(12'h126, 1'b1);
        nxt(`ICT_OP_SKBC, 8'h08, 2'h0, 12'h003);
        fp(12'h127, 1'b0);
        chk("acc", 12'(acc_r), 12'h0a5);
        op(`ICT_OP_XFER_A_I, 8'h42);
        fp(12'h128, 1'b0);
        nxt(`ICT_OP_XFER_M_A, 8'h00, 2'h3, 12'h000);
        op(`ICT_OP_NOP, 8'h00);
        fp(12'h142, 1'b1);
        chk("we", 12'(mem_we_r), 12'h000);
        nxt(`ICT_OP_CLEAR, 8'h00, 2'h3, 12'h000);
        op(`ICT_OP_NOP, 8'h00);
        fp(12'h100, 1'b1);
        op(`ICT_OP_NOP, 8'h00);
        fp(12'h100, 1'b0);
        $display("done flow");
    endtask
    // all inputs defined at time zero; the first instruction is a no-op
    initial begin
        nrst = 1'b0;
        op_code = `ICT_OP_NOP;
        op_operand = 8'h00;
        op_bit = 3'h0;
        op_to_mem = 1'b0;
        op_dest_pc_low = 1'b0;
        op_addr = 12'h000;
        tbl_data = 8'h00;
        t_reset();
        t_alu();
        t_flow();
        close_out();
    end
endmodule
`default_nettype wire
